// File: inc/dpf_pkg.sv
// Constants and types for the double-precision pipeline interlock
`default_nettype none
package dpf_pkg;
  // ----------------------------------------------------------------
  // Register file shape
  // ----------------------------------------------------------------
  localparam int unsigned REG_CNT = 16;  // Data registers seen by the interlock
  localparam int unsigned RIDX_W  = 4;   // Register index width
  localparam int unsigned DATA_W  = 32;  // One data register
  localparam int unsigned STALL_W = 3;   // Stall count width
  // ----------------------------------------------------------------
  // Stall counts
  // ----------------------------------------------------------------
  localparam logic [2:0] STALL_NONE  = 3'h0;
  localparam logic [2:0] STALL_ONE   = 3'h1;  // Late or partial dependency
  localparam logic [2:0] STALL_TWO   = 3'h2;  // Dependency on first-cycle read
  localparam logic [2:0] INH_LONG    = 3'h5;  // Add/sub/compare and multiply
  localparam logic [2:0] INH_CONV    = 3'h2;  // Four-cycle class incl. convert
  localparam logic [2:0] INH_SHORT   = 3'h0;  // Two-cycle class
  localparam logic [2:0] FWD_EXTRA   = 3'h1;  // Forward dependency surcharge
  localparam logic [2:0] OCC_RST     = 3'h0;
  // ----------------------------------------------------------------
  // Result timing, in cycles of the reference sequence
  // ----------------------------------------------------------------
  localparam int unsigned REF_ACCEPT_CYC = 6;   // Instruction leaves D2 unstalled
  localparam int unsigned REF_RES_LONG   = 17;  // Long class flags/result ready
  localparam int unsigned REF_RES_CONV   = 15;  // Four-cycle class
  localparam int unsigned REF_RES_SHORT  = 12;  // Two-cycle class
  localparam int unsigned LAT_LONG  = REF_RES_LONG - REF_ACCEPT_CYC;
  localparam int unsigned LAT_CONV  = REF_RES_CONV - REF_ACCEPT_CYC;
  localparam int unsigned LAT_SHORT = REF_RES_SHORT - REF_ACCEPT_CYC;
  localparam int unsigned RES_PIPE_W = 12;
  localparam logic [11:0] RES_PIPE_RST = 12'h000;
  // ----------------------------------------------------------------
  // Instruction classes and interlock states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_ADD    = 3'b000,  // Add, subtract, compare on pairs
    CLS_MUL_PP = 3'b001,  // Pair by pair multiply
    CLS_MUL_PS = 3'b010,  // Pair by single multiply
    CLS_MUL_SS = 3'b011,  // Single by single, pair result
    CLS_CONV   = 3'b100,  // Fix, truncate_to_int, scaled float, precision_convert
    CLS_SHORT  = 3'b101   // Negate, abs, pass, float, widen, exponent_scale
  } dpf_cls_type;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,  // Evaluate presented instruction
    ST_HOLD = 2'b01,  // Counting out stall cycles
    ST_GO   = 2'b10   // Stall served, release instruction
  } dpf_state_type;
endpackage
`default_nettype wire

// File: core/dpf_interlock.sv
// Double-precision stall interlock, result timing and long-word pair mapping
`timescale 1ns/1ps
`default_nettype none
module dpf_interlock
  import dpf_pkg::*;
(
  input  wire logic                  sys_clk_i,        // Core clock
  input  wire logic                  rst_i,            // Synchronous, active high
  input  wire logic                  dec_valid_i,      // Instruction waits in D2
  input  wire logic                  dec_is_dp_i,      // It is double precision
  input  wire dpf_cls_type           dec_cls_i,        // Its timing class
  input  wire logic [RIDX_W-1:0]     dec_src_a_i,      // First source index
  input  wire logic [RIDX_W-1:0]     dec_src_b_i,      // Second source index
  input  wire logic [REG_CNT-1:0]    dec_src_mask_i,   // All registers read
  input  wire logic [REG_CNT-1:0]    dec_dst_mask_i,   // All registers written
  input  wire logic                  dec_rd_flags_i,   // Reads arith_status_flags
  input  wire logic                  dec_wr_flags_i,   // Writes arith_status_flags
  input  wire logic                  lw_valid_i,       // Long-word load arrives
  input  wire logic [RIDX_W-1:0]     lw_reg_i,         // Named pair or register
  input  wire logic                  lw_secondary_i,   // Secondary element file
  input  wire logic [DATA_W-1:0]     lw_even_word_i,   // Even memory word
  input  wire logic [DATA_W-1:0]     lw_odd_word_i,    // Odd memory word
  output logic                       hold_o,           // Freeze fetch and decode
  output logic                       bubble_o,         // Insert bubble into M1
  output logic                       accept_o,         // Instruction moves to M1
  output logic [STALL_W-1:0]         stall_cnt_o,      // Last stall count served
  output logic                       res_valid_o,      // Result and flags ready
  output logic                       wr_valid_o,       // Register write pair valid
  output logic                       wr_secondary_o,   // Write targets secondary file
  output logic [RIDX_W-1:0]          wr_even_idx_o,    // Lower half register
  output logic [RIDX_W-1:0]          wr_odd_idx_o,     // Upper half register
  output logic [DATA_W-1:0]          wr_even_data_o,   // Data for lower half
  output logic [DATA_W-1:0]          wr_odd_data_o     // Data for upper half
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [RIDX_W-1:0] lo_of(input logic [RIDX_W-1:0] idx);
    lo_of = {idx[RIDX_W-1:1], 1'b0};  // Even member of the pair
  endfunction

  function automatic logic [RIDX_W-1:0] hi_of(input logic [RIDX_W-1:0] idx);
    hi_of = {idx[RIDX_W-1:1], 1'b1};  // Odd member of the pair
  endfunction

  function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b);
    max3 = (a > b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpf_state_type          st_reg;        // Interlock state
  dpf_state_type          st_next;
  logic [STALL_W-1:0]     cnt_reg;       // Remaining hold cycles
  logic [STALL_W-1:0]     occ_reg;       // Inherent stall still owed by N-1
  logic [REG_CNT-1:0]     m1_reg;        // Registers written by N-1
  logic [REG_CNT-1:0]     m2_reg;        // Registers written by N-2
  logic                   n1_dp_reg;     // N-1 was double precision
  logic                   n1_flags_reg;  // N-1 wrote status flags
  logic [RES_PIPE_W-1:0]  res_pipe_reg;  // Result timing shift line
  logic [STALL_W-1:0]     stall_reg;     // Last stall served
  logic [STALL_W-1:0]     need;          // Stall owed by presented instruction
  logic [2:0]             dep_stall;     // Source read hazard stall
  logic [2:0]             fwd_stall;     // Inherent plus forward surcharge
  logic                   hi1;           // N-1 wrote an upper add source
  logic                   lo1;           // N-1 wrote a lower add source
  logic                   hi2;           // N-2 wrote an upper add source

  // ----------------------------------------------------------------
  // Hazard evaluation
  // ----------------------------------------------------------------
  assign hi1 = m1_reg[hi_of(dec_src_a_i)] | m1_reg[hi_of(dec_src_b_i)];
  assign lo1 = m1_reg[lo_of(dec_src_a_i)] | m1_reg[lo_of(dec_src_b_i)];
  assign hi2 = m2_reg[hi_of(dec_src_a_i)] | m2_reg[hi_of(dec_src_b_i)];

  // Backward stall by read order; higher priority terms dominate via the if-else order
  always_comb begin
    dep_stall = STALL_NONE;
    if (dec_is_dp_i) begin
      case (dec_cls_i)
        CLS_ADD: begin
          // Upper halves read first, lower halves a cycle later
          if (hi1) dep_stall = STALL_TWO;
          else if (lo1 || hi2) dep_stall = STALL_ONE;
        end
        CLS_MUL_PP, CLS_MUL_PS: begin
          if (m1_reg[lo_of(dec_src_a_i)] || m1_reg[dec_src_b_i & {RIDX_W{1'b1}}]
              && (dec_cls_i == CLS_MUL_PS || !dec_src_b_i[0])) dep_stall = STALL_TWO;
          else if (m1_reg[hi_of(dec_src_a_i)]) dep_stall = STALL_ONE;
          else if (m2_reg[lo_of(dec_src_a_i)] || m2_reg[dec_src_b_i]) dep_stall = STALL_ONE;
        end
        CLS_MUL_SS: begin
          if (m1_reg[dec_src_a_i] || m1_reg[dec_src_b_i]) dep_stall = STALL_TWO;
          else if (m2_reg[dec_src_a_i] || m2_reg[dec_src_b_i]) dep_stall = STALL_ONE;
        end
        default: begin
          // All sources read in the first execute cycle
          if (|(m1_reg & dec_src_mask_i)) dep_stall = STALL_TWO;
          else if (|(m2_reg & dec_src_mask_i)) dep_stall = STALL_ONE;
        end
      endcase
    end
  end

  // Follower of a double op owes the inherent stall, plus one if single precision and dependent
  always_comb begin
    fwd_stall = occ_reg;
    if (n1_dp_reg && !dec_is_dp_i &&
        ((|(m1_reg & dec_src_mask_i)) || (n1_flags_reg && dec_rd_flags_i))) begin
      fwd_stall = occ_reg + FWD_EXTRA;
    end
  end

  assign need = max3(dep_stall, fwd_stall);

  // ----------------------------------------------------------------
  // Hold sequencing
  // ----------------------------------------------------------------
  // Handshake outputs are combinational so the front end freezes at once
  always_comb begin
    hold_o = 1'b0;
    case (st_reg)
      ST_RUN:  hold_o = dec_valid_i && (need != STALL_NONE);
      ST_HOLD: hold_o = 1'b1;
      ST_GO:   hold_o = 1'b0;
      default: hold_o = 1'b0;
    endcase
  end
  assign bubble_o = hold_o;
  assign accept_o = dec_valid_i && !hold_o;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_RUN:  if (hold_o) st_next = (need == STALL_ONE) ? ST_GO : ST_HOLD;
      ST_HOLD: if (cnt_reg == STALL_ONE) st_next = ST_GO;
      ST_GO:   st_next = ST_RUN;
      default: st_next = ST_RUN;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) st_reg <= ST_RUN;
    else st_reg <= st_next;
  end

  // Hold counter; first held cycle is spent in the evaluate state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) cnt_reg <= STALL_NONE;
    else if (st_reg == ST_RUN && hold_o) cnt_reg <= need - STALL_ONE;
    else if (st_reg == ST_HOLD) cnt_reg <= cnt_reg - STALL_ONE;
  end

  // Last stall served, captured when the stall starts
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) stall_reg <= STALL_NONE;
    else if (st_reg == ST_RUN && dec_valid_i) stall_reg <= need;
  end
  assign stall_cnt_o = stall_reg;

  // ----------------------------------------------------------------
  // Occupancy and history
  // ----------------------------------------------------------------
  // Occupancy drains with time, so idle cycles also pay it off
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) occ_reg <= OCC_RST;
    else if (accept_o && dec_is_dp_i) begin
      case (dec_cls_i)
        CLS_ADD:                          occ_reg <= INH_LONG;
        CLS_MUL_PP, CLS_MUL_PS, CLS_MUL_SS: occ_reg <= INH_LONG;
        CLS_CONV:                         occ_reg <= INH_CONV;
        default:                          occ_reg <= INH_SHORT;
      endcase
    end else if (accept_o) occ_reg <= OCC_RST;
    else if (occ_reg != OCC_RST) occ_reg <= occ_reg - STALL_ONE;
  end

  // Destination history ages per accepted instruction only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      m1_reg       <= '0;
      m2_reg       <= '0;
      n1_dp_reg    <= 1'b0;
      n1_flags_reg <= 1'b0;
    end else if (accept_o) begin
      m1_reg       <= dec_dst_mask_i;
      m2_reg       <= m1_reg;
      n1_dp_reg    <= dec_is_dp_i;
      n1_flags_reg <= dec_wr_flags_i;
    end
  end

  // ----------------------------------------------------------------
  // Result and flag timing
  // ----------------------------------------------------------------
  // A one-hot mark walks down to bit zero; stalls after accept shift it too
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) res_pipe_reg <= RES_PIPE_RST;
    else begin
      res_pipe_reg <= {1'b0, res_pipe_reg[RES_PIPE_W-1:1]};
      if (accept_o && dec_is_dp_i) begin
        case (dec_cls_i)
          CLS_CONV:  res_pipe_reg[LAT_CONV-1]  <= 1'b1;
          CLS_SHORT: res_pipe_reg[LAT_SHORT-1] <= 1'b1;
          default:   res_pipe_reg[LAT_LONG-1]  <= 1'b1;
        endcase
      end
    end
  end
  assign res_valid_o = res_pipe_reg[0];

  // ----------------------------------------------------------------
  // Long-word pair mapping
  // ----------------------------------------------------------------
  // Pair name and even name give the same target; alignment is the
  // program's duty, so no check is made here
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_valid_o     <= 1'b0;
      wr_secondary_o <= 1'b0;
      wr_even_idx_o  <= '0;
      wr_odd_idx_o   <= '0;
      wr_even_data_o <= '0;
      wr_odd_data_o  <= '0;
    end else begin
      wr_valid_o     <= lw_valid_i;
      wr_secondary_o <= lw_secondary_i;
      wr_even_idx_o  <= lo_of(lw_reg_i);
      wr_odd_idx_o   <= hi_of(lw_reg_i);
      wr_even_data_o <= lw_even_word_i;
      wr_odd_data_o  <= lw_odd_word_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_add_upper_two: assert property (
    (st_reg == ST_RUN && dec_valid_i && dec_is_dp_i && dec_cls_i == CLS_ADD && hi1
     && occ_reg == OCC_RST) |-> hold_o ##1 hold_o ##1 (st_reg == ST_GO))
    else $error("add upper hazard not two stalls");
  chk_mixed_one_two: assert property (
    (st_reg == ST_RUN && dec_valid_i && dec_is_dp_i && dec_cls_i == CLS_ADD && hi1 && hi2
     && occ_reg == OCC_RST) |-> need == STALL_TWO)
    else $error("mixed hazards not two stalls");
  chk_two_ones_one: assert property (
    (st_reg == ST_RUN && dec_valid_i && dec_is_dp_i && dec_cls_i == CLS_ADD && !hi1
     && lo1 && hi2 && occ_reg == OCC_RST) |-> hold_o ##1 (st_reg == ST_GO && !hold_o))
    else $error("two one-cycle hazards summed");
  chk_max_not_sum: assert property (
    (st_reg == ST_RUN && dec_valid_i) |-> (need >= dep_stall && need >= fwd_stall
     && (need == dep_stall || need == fwd_stall)))
    else $error("stall not maximum of causes");
  chk_fwd_extra: assert property (
    (st_reg == ST_RUN && n1_dp_reg && !dec_is_dp_i && |(m1_reg & dec_src_mask_i))
    |-> need >= occ_reg + FWD_EXTRA)
    else $error("forward dependency surcharge missing");
  chk_long_occupy: assert property (
    (accept_o && dec_is_dp_i && dec_cls_i == CLS_ADD) |=> occ_reg == INH_LONG)
    else $error("add class occupancy wrong");
  chk_mul_occupy: assert property (
    (accept_o && dec_is_dp_i && (dec_cls_i == CLS_MUL_PP || dec_cls_i == CLS_MUL_SS))
    |=> occ_reg == INH_LONG)
    else $error("multiply occupancy wrong");
  chk_conv_occupy: assert property (
    (accept_o && dec_is_dp_i && dec_cls_i == CLS_CONV) |=> occ_reg == INH_CONV)
    else $error("convert stall wrong");
  chk_conv_result: assert property (
    (accept_o && dec_is_dp_i && dec_cls_i == CLS_CONV) |-> ##9 res_valid_o)
    else $error("four-cycle result late");
  chk_short_result: assert property (
    (accept_o && dec_is_dp_i && dec_cls_i == CLS_SHORT) |-> ##6 res_valid_o)
    else $error("two-cycle result late");
  chk_long_result: assert property (
    (accept_o && dec_is_dp_i && dec_cls_i == CLS_ADD) |-> ##11 res_valid_o)
    else $error("long result late");
  chk_hold_freeze: assert property (
    (st_reg == ST_HOLD) |-> (hold_o && bubble_o && !accept_o && cnt_reg != STALL_NONE))
    else $error("front end not frozen");
  chk_pair_map: assert property (
    lw_valid_i |=> (wr_valid_o && !wr_even_idx_o[0] && wr_odd_idx_o == wr_even_idx_o + 4'h1))
    else $error("pair halves mismapped");
  chk_word_order: assert property (
    lw_valid_i |=> (wr_even_data_o == $past(lw_even_word_i)
                    && wr_odd_data_o == $past(lw_odd_word_i)))
    else $error("long-word order swapped");

  cov_add_stall: cover property (st_reg == ST_GO && dec_is_dp_i && dec_cls_i == CLS_ADD);
  cov_fwd_stall: cover property (st_reg == ST_RUN && n1_dp_reg && !dec_is_dp_i && hold_o);
  cov_result:    cover property (res_valid_o);
  cov_lw_load:   cover property (wr_valid_o && wr_secondary_o);
endmodule
`default_nettype wire

// File: sim/dpf_interlock_tb.sv
// Self-checking bench for the double-precision stall interlock
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dpf_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, observed outputs and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {
    logic               dp;  // Double precision
    dpf_cls_type        cls; // Timing class
    logic [RIDX_W-1:0]  a;   // First source
    logic [RIDX_W-1:0]  b;   // Second source
    logic [REG_CNT-1:0] sm;  // Registers read
    logic [REG_CNT-1:0] dm;  // Registers written
    logic               rf;  // Reads status flags
    logic               wf;  // Writes status flags
    logic [STALL_W-1:0] st;  // Expected hold cycles
  } dpf_row_type;
  localparam int        TICK_CEIL = 2000;  // Whole run needs well under this
  logic                 sys_clk_i      = 1'b0;
  logic                 rst_i          = 1'b1;
  logic                 dec_valid_i    = 1'b0;
  logic                 dec_is_dp_i    = 1'b0;
  dpf_cls_type          dec_cls_i      = CLS_ADD;
  logic [RIDX_W-1:0]    dec_src_a_i    = 4'h0;
  logic [RIDX_W-1:0]    dec_src_b_i    = 4'h0;
  logic [REG_CNT-1:0]   dec_src_mask_i = 16'h0000;
  logic [REG_CNT-1:0]   dec_dst_mask_i = 16'h0000;
  logic                 dec_rd_flags_i = 1'b0;
  logic                 dec_wr_flags_i = 1'b0;
  logic                 lw_valid_i     = 1'b0;
  logic [RIDX_W-1:0]    lw_reg_i       = 4'h0;
  logic                 lw_secondary_i = 1'b0;
  logic [DATA_W-1:0]    lw_even_word_i = 32'h0000_0000;
  logic [DATA_W-1:0]    lw_odd_word_i  = 32'h0000_0000;
  logic                 hold_o, bubble_o, accept_o, res_valid_o, wr_valid_o, wr_secondary_o;
  logic [STALL_W-1:0]   stall_cnt_o;
  logic [RIDX_W-1:0]    wr_even_idx_o, wr_odd_idx_o;
  logic [DATA_W-1:0]    wr_even_data_o, wr_odd_data_o;
  int                   err_total = 0;  // Mismatches
  int                   cmp_count = 0;  // Comparisons
  int                   tick = 0;       // Watchdog count
  int                   cyc = 0;        // Cycle index for result timing
  int                   pend[$];        // Cycles at which a result is due
  int                   lat;            // Latency of the accepted class
  logic                 res_exp;        // Result pulse expected now
  dpf_row_type          rows [0:26];    // Back-to-back instruction stream
  dpf_row_type          t;              // Scratch row
  logic [RIDX_W-1:0]    lw_regs [0:3] = '{4'h5, 4'h4, 4'hf, 4'h0};

  // Free-running 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  dpf_interlock dpf_interlock_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .dec_valid_i(dec_valid_i),
    .dec_is_dp_i(dec_is_dp_i), .dec_cls_i(dec_cls_i), .dec_src_a_i(dec_src_a_i),
    .dec_src_b_i(dec_src_b_i), .dec_src_mask_i(dec_src_mask_i),
    .dec_dst_mask_i(dec_dst_mask_i), .dec_rd_flags_i(dec_rd_flags_i),
    .dec_wr_flags_i(dec_wr_flags_i), .lw_valid_i(lw_valid_i), .lw_reg_i(lw_reg_i),
    .lw_secondary_i(lw_secondary_i), .lw_even_word_i(lw_even_word_i),
    .lw_odd_word_i(lw_odd_word_i), .hold_o(hold_o), .bubble_o(bubble_o),
    .accept_o(accept_o), .stall_cnt_o(stall_cnt_o), .res_valid_o(res_valid_o),
    .wr_valid_o(wr_valid_o), .wr_secondary_o(wr_secondary_o),
    .wr_even_idx_o(wr_even_idx_o), .wr_odd_idx_o(wr_odd_idx_o),
    .wr_even_data_o(wr_even_data_o), .wr_odd_data_o(wr_odd_data_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Present one instruction; fields stay put while it is held
  task automatic set_fields(input dpf_row_type r);
    dec_valid_i    = 1'b1;
    dec_is_dp_i    = r.dp;
    dec_cls_i      = r.cls;
    dec_src_a_i    = r.a;
    dec_src_b_i    = r.b;
    dec_src_mask_i = r.sm;
    dec_dst_mask_i = r.dm;
    dec_rd_flags_i = r.rf;
    dec_wr_flags_i = r.wf;
  endtask

  // Count hold cycles until accept, bounded so a stuck hold cannot hang
  task automatic issue(input dpf_row_type r);
    int n;
    set_fields(r);
    n = 0;
    #1;
    while (accept_o !== 1'b1 && n < 12) begin
      check("hold_o", hold_o, 1'b1);
      check("bubble_o", bubble_o, 1'b1);
      n++;
      @(negedge sys_clk_i);
      #1;
    end
    check("hold_o", hold_o, 1'b0);
    check("stall", n, r.st);
    @(negedge sys_clk_i);
    // Count is latched on the first presented cycle and then kept
    check("stall_cnt_o", stall_cnt_o, r.st);
  endtask

  // Reset in mid-run: no hold, no history, registered outputs cleared
  // Reset is synchronous, so old occupancy may still hold until its first edge
  task automatic pulse_reset();
    rst_i = 1'b1;
    set_fields(rows[23]);
    @(negedge sys_clk_i);
    check("hold_o", hold_o, 1'b0);
    check("accept_o", accept_o, 1'b1);
    @(negedge sys_clk_i);
    check("wr_valid_o", wr_valid_o, 1'b0);
    check("res_valid_o", res_valid_o, 1'b0);
    check("stall_cnt_o", stall_cnt_o, 3'h0);
    rst_i = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Watchdog and result timing monitor
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    tick++;
    if (tick >= TICK_CEIL) begin
      err_total++;
      complete_run();
    end
  end

  // Result pulse due a fixed latency after each double accept
  always @(posedge sys_clk_i) begin
    cyc++;
    if (rst_i) begin
      pend.delete();
    end else begin
      res_exp = (pend.size() > 0) && (pend[0] == cyc);
      check("res_valid_o", res_valid_o, res_exp);
      while (pend.size() > 0 && pend[0] == cyc) begin
        void'(pend.pop_front());
      end
      if (accept_o === 1'b1 && dec_valid_i && dec_is_dp_i) begin
        lat = (dec_cls_i == CLS_CONV) ? LAT_CONV : (dec_cls_i == CLS_SHORT) ? LAT_SHORT : LAT_LONG;
        pend.push_back(cyc + lat);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0008, 1'b0, 1'b0, 3'h0},
      '{1'b1, CLS_ADD,    4'h2, 4'h0, 16'h000f, 16'h0030, 1'b0, 1'b1, 3'h2},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0030, 16'h0800, 1'b0, 1'b0, 3'h6},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0002, 1'b0, 1'b0, 3'h0},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0008, 1'b0, 1'b0, 3'h0},
      '{1'b1, CLS_ADD,    4'h2, 4'h0, 16'h000f, 16'h0030, 1'b0, 1'b1, 3'h2},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h5},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0002, 1'b0, 1'b0, 3'h0},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0001, 1'b0, 1'b0, 3'h0},
      '{1'b1, CLS_ADD,    4'h2, 4'h0, 16'h000f, 16'h0030, 1'b0, 1'b1, 3'h1},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h5},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0002, 1'b0, 1'b0, 3'h0},
      '{1'b1, CLS_CONV,   4'ha, 4'h0, 16'h0c00, 16'h8000, 1'b0, 1'b1, 3'h0},
      '{1'b1, CLS_ADD,    4'h2, 4'h0, 16'h000f, 16'h0030, 1'b0, 1'b1, 3'h2},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h5},
      '{1'b1, CLS_CONV,   4'ha, 4'h0, 16'h0c00, 16'h8000, 1'b0, 1'b1, 3'h0},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b1, 1'b0, 3'h3},
      '{1'b1, CLS_MUL_PP, 4'h2, 4'h0, 16'h000f, 16'h0030, 1'b0, 1'b1, 3'h0},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h5},
      '{1'b1, CLS_MUL_SS, 4'h2, 4'h0, 16'h0005, 16'h0030, 1'b0, 1'b1, 3'h0},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0010, 16'h0800, 1'b0, 1'b0, 3'h6},
      '{1'b1, CLS_SHORT,  4'h2, 4'h0, 16'h000d, 16'h0030, 1'b0, 1'b1, 3'h0},
      '{1'b1, CLS_SHORT,  4'h4, 4'h0, 16'h0030, 16'h00c0, 1'b0, 1'b1, 3'h2},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h0},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0004, 1'b0, 1'b0, 3'h0},
      '{1'b1, CLS_MUL_PS, 4'h2, 4'h0, 16'h0005, 16'h0030, 1'b0, 1'b1, 3'h2},
      '{1'b0, CLS_ADD,    4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h5}};
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    foreach (rows[k]) begin
      issue(rows[k]);
    end
    dec_valid_i = 1'b0;
    // Long-word loads every cycle, alternating element files; odd names 5 and f map to their aligned pairs
    for (int i = 0; i < 6; i++) begin
      if (i > 0) begin
        check("wr_valid_o", wr_valid_o, i < 5);
      end
      if (i > 0 && i < 5) begin
        check("wr_even_idx_o", wr_even_idx_o, {lw_reg_i[3:1], 1'b0});
        check("wr_odd_idx_o", wr_odd_idx_o, {lw_reg_i[3:1], 1'b1});
        check("wr_even_data_o", wr_even_data_o, lw_even_word_i);
        check("wr_odd_data_o", wr_odd_data_o, lw_odd_word_i);
        check("wr_secondary_o", wr_secondary_o, lw_secondary_i);
      end
      lw_valid_i = (i < 4);
      if (i < 4) begin
        lw_reg_i       = lw_regs[i];
        lw_secondary_i = i[0];
        lw_even_word_i = 32'ha5a5_0000 | 32'(i);
        lw_odd_word_i  = 32'h5a5a_0000 | 32'(i);
      end
      @(negedge sys_clk_i);
    end
    // History and occupancy do not survive a reset
    issue(rows[0]);
    pulse_reset();
    t = rows[1];
    t.st = 3'h0;
    issue(t);
    pulse_reset();
    issue(rows[23]);
    dec_valid_i = 1'b0;
    repeat (14) @(negedge sys_clk_i);
    complete_run();
  end
endmodule
`default_nettype wire
